// ==== sscbf_pkg.sv ====
// Purpose: Shared constants and types for the split snooping cache.
// Assumes: 32-bit physical addresses, 32-bit bus words.
// Notes:   Address = tag | set index | word select | byte offset.
package sscbf_pkg;
	localparam int ADDR_W     = 32;
	localparam int DATA_W     = 32;
	localparam int WAYS       = 4;
	localparam int WAY_W      = 2;
	localparam int SETS       = 64;
	localparam int IDX_W      = 6;
	localparam int WORDS      = 4;
	localparam int BEAT_W     = 2;
	localparam int LINE_W     = 128;
	localparam int WSEL_LSB   = 2;
	localparam int IDX_LSB    = 4;
	localparam int TAG_LSB    = 10;
	localparam int TAG_W      = 22;
	localparam int FIFO_DEPTH = 32;
	localparam int CI         = 0;	// Instruction cache index
	localparam int CD         = 1;	// Data cache index
	localparam logic [IDX_LSB-1:0] LINE_OFS0 = 4'h0;
	localparam logic [BEAT_W-1:0]  BEAT_LAST = 2'h3;
	// Page cache mode from the two descriptor bits
	localparam logic [1:0] PM_WT = 2'h0;	// Write-through
	localparam logic [1:0] PM_CB = 2'h1;	// Copyback
	// Line state
	typedef enum logic [1:0] {
		LS_INV   = 2'h0,
		LS_CLEAN = 2'h1,
		LS_DIRTY = 2'h2
	} sscbf_lstate_t;
	// Bus controller states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_WBACK = 4'h2,
		ST_FILL  = 4'h4,
		ST_WT    = 4'h8
	} sscbf_fsm_t;
	typedef struct packed {
		sscbf_lstate_t      st;
		logic [TAG_W-1:0]   tag;
		logic [LINE_W-1:0]  data;
	} sscbf_line_t;
endpackage

// ==== sscbf_stream_if.sv ====
// Purpose: Valid/ready word stream between the cache modules.
// Assumes: Transfer when valid and ready are both high at a clock edge.
// Notes:   src drives data, snk drives ready.
`timescale 1ns/1ps
interface sscbf_stream_if #(parameter int W = 32) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface // sscbf_stream_if

// ==== sscbf_fifo.sv ====
// Purpose: Word FIFO for burst read data from the system bus.
// Assumes: Single clock; pop data is valid while out_s.valid is high.
// Notes:   Storage is a register array; read data is a stored word.
`timescale 1ns/1ps
module sscbf_fifo #(
	parameter int W = 32,	// Word width
	parameter int D = 32	// Depth in words
) (
	input  logic            clock,	// System clock
	input  logic            reset_n,	// Async reset, active low
	sscbf_stream_if.snk     in_s,	// Fill side
	sscbf_stream_if.src     out_s	// Drain side
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
	} sscbf_fifo_st_t;

	sscbf_fifo_st_t q;
	sscbf_fifo_st_t d;
	logic           push;
	logic           pop;

	// Honest flags: full stops the source, empty stops the sink
	assign in_s.ready  = q.cnt != (AW+1)'(D);
	assign out_s.valid = q.cnt != '0;
	assign out_s.data  = q.mem[q.rp];
	assign push        = in_s.valid && in_s.ready;
	assign pop         = out_s.valid && out_s.ready;

	// Pointers wrap after entry D-1, so any depth works
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = in_s.data;
			d.wp = (q.wp == AW'(D-1)) ? '0 : q.wp + 1'b1;
		end
		if (pop) begin
			d.rp = (q.rp == AW'(D-1)) ? '0 : q.rp + 1'b1;
		end
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	// State register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule // sscbf_fifo

// ==== sscbf_top.sv ====
// Purpose: Split instruction/data cache with bus snooping and burst fill.
// Assumes: Memory acks one word per cycle; snoop inputs sampled each cycle.
// Notes:   One bus controller serves both caches; read and copyback write hits do not wait for it.
// Functional notes
// - Both caches four-way, 16-byte lines
// - Each line holds tag and valid state
// - Data lines invalid, clean or dirty
// - Only snoopable bus cycles are checked
// - Snoop decides conflict from line state alone
// - Snooped writes check both caches
// - Snooped reads check data cache only
// - Snoop wins cache access over clients
// - Separate address and data, burst both ways
// - Line fill is one four-word burst
// - Burst write: 128 bits, five cycles
// - Read and copyback write hits proceed while bus is busy
// - Write-through write miss never allocates
`timescale 1ns/1ps
module sscbf_top #(
	parameter int FIFO_D = sscbf_pkg::FIFO_DEPTH	// Fill FIFO depth
) (
	input  logic        clock,	// 40 MHz system clock
	input  logic        reset_n,	// Async reset, active low
	input  logic        i_req,	// Instruction fetch request
	input  logic [31:0] i_addr,	// Fetch address
	output logic        i_ack,	// Fetch done, one cycle
	output logic [31:0] i_rdata,	// Fetched word
	input  logic        d_req,	// Data access request
	input  logic        d_we,	// Data write
	input  logic [31:0] d_addr,	// Data address
	input  logic [31:0] d_wdata,	// Write word
	input  logic [1:0]  d_page_mode,	// Page cache mode bits
	output logic        d_ack,	// Data access done, one cycle
	output logic [31:0] d_rdata,	// Read word
	input  logic        snp_valid,	// Other master bus cycle
	input  logic        snp_snoopable,	// Cycle marked snoopable
	input  logic        snp_write,	// Cycle is a write
	input  logic [31:0] snp_addr,	// Cycle address
	output logic        snp_hit,	// Snoop hit, one cycle
	output logic        snp_conflict,	// Snoop hit a dirty line
	output logic        bus_start,	// Address phase, one cycle
	output logic [31:0] bus_addr,	// Bus address
	output logic        bus_write,	// Bus cycle is a write
	output logic        bus_burst,	// Four-word burst
	output logic [31:0] bus_wdata,	// Write beat data
	input  logic        mem_ack,	// Data beat taken or valid
	input  logic [31:0] mem_rdata,	// Read beat data
	output logic        mem_ready	// Read beat can be taken
);
	typedef struct packed {
		sscbf_pkg::sscbf_line_t [1:0][sscbf_pkg::SETS-1:0]
			[sscbf_pkg::WAYS-1:0] ln;
		logic [1:0][sscbf_pkg::WAY_W-1:0] vict;
		sscbf_pkg::sscbf_fsm_t            st;
		logic                             cache;
		logic [31:0]                      addr;
		logic [sscbf_pkg::WAY_W-1:0]      way;
		logic [sscbf_pkg::BEAT_W-1:0]     beat;
		logic [sscbf_pkg::LINE_W-1:0]     lbuf;
		logic                             stale;
		logic                             i_ack;
		logic [31:0]                      i_rdata;
		logic                             d_ack;
		logic [31:0]                      d_rdata;
		logic                             bus_start;
		logic [31:0]                      bus_addr;
		logic                             bus_write;
		logic                             bus_burst;
		logic [31:0]                      bus_wdata;
		logic                             snp_hit;
		logic                             snp_conflict;
	} sscbf_state_t;

	sscbf_state_t                 q;
	sscbf_state_t                 d;
	logic [sscbf_pkg::WAYS-1:0]   ihit;
	logic [sscbf_pkg::WAYS-1:0]   dhit;
	logic [sscbf_pkg::WAYS-1:0]   sihit;
	logic [sscbf_pkg::WAYS-1:0]   sdhit;
	logic [sscbf_pkg::WAYS-1:0]   sddirty;
	logic [sscbf_pkg::IDX_W-1:0]  iidx;
	logic [sscbf_pkg::IDX_W-1:0]  didx;
	logic [sscbf_pkg::IDX_W-1:0]  sidx;
	logic [sscbf_pkg::IDX_W-1:0]  aidx;
	logic [sscbf_pkg::BEAT_W-1:0] iwsel;
	logic [sscbf_pkg::BEAT_W-1:0] dwsel;
	logic [sscbf_pkg::WAY_W-1:0]  dway;
	logic [sscbf_pkg::WAY_W-1:0]  vw;
	logic                         snp_act;
	logic                         d_cab;
	logic                         d_new;
	logic                         i_new;
	logic                         alloc;
	logic                         ac;
	logic [31:0]                  aa;
	sscbf_pkg::sscbf_line_t       vline;

	sscbf_stream_if #(.W(sscbf_pkg::DATA_W)) fin ();
	sscbf_stream_if #(.W(sscbf_pkg::DATA_W)) fout ();

	// Read beats queue here so a snoop can stall the line install
	sscbf_fifo #(.W(sscbf_pkg::DATA_W), .D(FIFO_D)) u_fifo (
		.clock   (clock),
		.reset_n (reset_n),
		.in_s    (fin),
		.out_s   (fout)
	);
	assign fin.valid  = mem_ack && q.st == sscbf_pkg::ST_FILL;
	assign fin.data   = mem_rdata;
	assign mem_ready  = fin.ready;
	assign fout.ready = q.st == sscbf_pkg::ST_FILL && !snp_act;

	// Address split and request qualifiers
	assign iidx    = i_addr[sscbf_pkg::IDX_LSB +: sscbf_pkg::IDX_W];
	assign didx    = d_addr[sscbf_pkg::IDX_LSB +: sscbf_pkg::IDX_W];
	assign sidx    = snp_addr[sscbf_pkg::IDX_LSB +: sscbf_pkg::IDX_W];
	assign iwsel   = i_addr[sscbf_pkg::WSEL_LSB +: sscbf_pkg::BEAT_W];
	assign dwsel   = d_addr[sscbf_pkg::WSEL_LSB +: sscbf_pkg::BEAT_W];
	assign snp_act = snp_valid && snp_snoopable;
	assign d_cab   = d_page_mode == sscbf_pkg::PM_WT
		|| d_page_mode == sscbf_pkg::PM_CB;
	assign i_new   = i_req && !q.i_ack;
	assign d_new   = d_req && !q.d_ack;

	// Tag compare per way for both client ports and the snooper
	for (genvar w = 0; w < sscbf_pkg::WAYS; w++) begin : g_way
		assign ihit[w] = q.ln[sscbf_pkg::CI][iidx][w].st
			!= sscbf_pkg::LS_INV && q.ln[sscbf_pkg::CI][iidx][w].tag
			== i_addr[sscbf_pkg::TAG_LSB +: sscbf_pkg::TAG_W];
		assign dhit[w] = q.ln[sscbf_pkg::CD][didx][w].st
			!= sscbf_pkg::LS_INV && q.ln[sscbf_pkg::CD][didx][w].tag
			== d_addr[sscbf_pkg::TAG_LSB +: sscbf_pkg::TAG_W];
		assign sihit[w] = q.ln[sscbf_pkg::CI][sidx][w].st
			!= sscbf_pkg::LS_INV && q.ln[sscbf_pkg::CI][sidx][w].tag
			== snp_addr[sscbf_pkg::TAG_LSB +: sscbf_pkg::TAG_W];
		assign sdhit[w] = q.ln[sscbf_pkg::CD][sidx][w].st
			!= sscbf_pkg::LS_INV && q.ln[sscbf_pkg::CD][sidx][w].tag
			== snp_addr[sscbf_pkg::TAG_LSB +: sscbf_pkg::TAG_W];
		assign sddirty[w] = sdhit[w] && q.ln[sscbf_pkg::CD][sidx][w].st
			== sscbf_pkg::LS_DIRTY;
	end

	// Hit way number from the one-hot hit vector
	always_comb begin
		dway = '0;
		for (int w = 0; w < sscbf_pkg::WAYS; w++) begin
			if (dhit[w]) begin
				dway = sscbf_pkg::WAY_W'(w);
			end
		end
	end

	// Miss decision: data port first, only one line move at a time
	always_comb begin
		alloc = 1'b0;
		ac    = 1'b0;
		aa    = {d_addr[31:sscbf_pkg::IDX_LSB], sscbf_pkg::LINE_OFS0};
		if (d_new && d_cab && !(|dhit)
			&& (!d_we || d_page_mode == sscbf_pkg::PM_CB)) begin
			alloc = 1'b1;
			ac    = 1'b1;
		end else if (i_new && !(|ihit) && !(d_new && !d_cab)) begin
			alloc = 1'b1;
			aa    = {i_addr[31:sscbf_pkg::IDX_LSB], sscbf_pkg::LINE_OFS0};
		end
		aidx  = aa[sscbf_pkg::IDX_LSB +: sscbf_pkg::IDX_W];
		vw    = q.vict[ac];
		vline = q.ln[ac][aidx][vw];
	end

	// Snooper, client hit paths, then the bus controller
	always_comb begin
		d              = q;
		d.i_ack        = 1'b0;
		d.d_ack        = 1'b0;
		d.bus_start    = 1'b0;
		d.snp_hit      = 1'b0;
		d.snp_conflict = 1'b0;
		if (snp_act) begin
			for (int w = 0; w < sscbf_pkg::WAYS; w++) begin
				if (snp_write && sihit[w]) begin
					d.ln[sscbf_pkg::CI][sidx][w].st = sscbf_pkg::LS_INV;
				end
				if (snp_write && sdhit[w]) begin
					d.ln[sscbf_pkg::CD][sidx][w].st = sscbf_pkg::LS_INV;
				end
			end
			d.snp_hit      = (|sdhit) || (snp_write && |sihit);
			d.snp_conflict = |sddirty;
			// A line being filled would install stale words
			if (snp_write && q.st == sscbf_pkg::ST_FILL && q.bus_burst
				&& snp_addr[31:sscbf_pkg::IDX_LSB]
				== q.addr[31:sscbf_pkg::IDX_LSB]) begin
				d.stale = 1'b1;
			end
		end
		// Read and copyback write hits run whatever the bus controller is doing
		if (i_new && !snp_act && |ihit) begin
			d.i_ack   = 1'b1;
			d.i_rdata = q.ln[sscbf_pkg::CI][iidx][0].data[0 +: 32];
			for (int w = 0; w < sscbf_pkg::WAYS; w++) begin
				if (ihit[w]) begin
					d.i_rdata = q.ln[sscbf_pkg::CI][iidx][w].data
						[iwsel*sscbf_pkg::DATA_W +: sscbf_pkg::DATA_W];
				end
			end
		end
		if (d_new && !snp_act && d_cab && |dhit) begin
			if (!d_we) begin
				d.d_ack   = 1'b1;
				d.d_rdata = q.ln[sscbf_pkg::CD][didx][dway].data
					[dwsel*sscbf_pkg::DATA_W +: sscbf_pkg::DATA_W];
			end else if (d_page_mode == sscbf_pkg::PM_CB) begin
				d.d_ack = 1'b1;
				d.ln[sscbf_pkg::CD][didx][dway].data
					[dwsel*sscbf_pkg::DATA_W +: sscbf_pkg::DATA_W] = d_wdata;
				d.ln[sscbf_pkg::CD][didx][dway].st = sscbf_pkg::LS_DIRTY;
			end
		end
		case (q.st)
			sscbf_pkg::ST_IDLE: begin
				if (snp_act) begin
					d.st = sscbf_pkg::ST_IDLE;
				end else if (d_new && d_we
					&& d_page_mode != sscbf_pkg::PM_CB) begin
					// Single write; a write-through hit is updated, keeps its line state
					if (d_cab && |dhit) begin
						d.ln[sscbf_pkg::CD][didx][dway].data
							[dwsel*sscbf_pkg::DATA_W +: sscbf_pkg::DATA_W]
							= d_wdata;
					end
					d.st        = sscbf_pkg::ST_WT;
					d.bus_start = 1'b1;
					d.bus_addr  = d_addr;
					d.bus_write = 1'b1;
					d.bus_burst = 1'b0;
					d.bus_wdata = d_wdata;
				end else if (d_new && !d_we && !d_cab) begin
					// Uncached read: one beat through the FIFO
					d.st        = sscbf_pkg::ST_FILL;
					d.cache     = 1'b1;
					d.addr      = d_addr;
					d.beat      = '0;
					d.bus_start = 1'b1;
					d.bus_addr  = d_addr;
					d.bus_write = 1'b0;
					d.bus_burst = 1'b0;
				end else if (alloc) begin
					d.cache     = ac;
					d.addr      = aa;
					d.way       = vw;
					d.beat      = '0;
					d.stale     = 1'b0;
					d.bus_start = 1'b1;
					d.bus_burst = 1'b1;
					d.ln[ac][aidx][vw].st = sscbf_pkg::LS_INV;
					if (vline.st == sscbf_pkg::LS_DIRTY) begin
						d.st        = sscbf_pkg::ST_WBACK;
						d.bus_write = 1'b1;
						d.bus_addr  = {vline.tag, aidx, sscbf_pkg::LINE_OFS0};
						d.bus_wdata = vline.data[0 +: sscbf_pkg::DATA_W];
					end else begin
						d.st        = sscbf_pkg::ST_FILL;
						d.bus_write = 1'b0;
						d.bus_addr  = aa;
					end
				end
			end
			sscbf_pkg::ST_WBACK: begin
				// One beat per ack; start plus four beats is five cycles
				if (mem_ack) begin
					if (q.beat == sscbf_pkg::BEAT_LAST) begin
						d.st        = sscbf_pkg::ST_FILL;
						d.beat      = '0;
						d.bus_start = 1'b1;
						d.bus_write = 1'b0;
						d.bus_addr  = q.addr;
					end else begin
						d.beat      = q.beat + 1'b1;
						d.bus_wdata = q.ln[q.cache][q.addr[sscbf_pkg::IDX_LSB
							+: sscbf_pkg::IDX_W]][q.way].data[(q.beat + 1'b1)
							* sscbf_pkg::DATA_W +: sscbf_pkg::DATA_W];
					end
				end
			end
			sscbf_pkg::ST_FILL: begin
				if (fout.valid && !snp_act) begin
					d.lbuf[q.beat*sscbf_pkg::DATA_W +: sscbf_pkg::DATA_W]
						= fout.data;
					d.beat = q.beat + 1'b1;
					if (!q.bus_burst) begin
						d.d_ack   = 1'b1;
						d.d_rdata = fout.data;
						d.st      = sscbf_pkg::ST_IDLE;
					end else if (q.beat == sscbf_pkg::BEAT_LAST) begin
						// Install the whole line at once
						d.ln[q.cache][q.addr[sscbf_pkg::IDX_LSB
							+: sscbf_pkg::IDX_W]][q.way] = '{
							st:   q.stale ? sscbf_pkg::LS_INV
								: sscbf_pkg::LS_CLEAN,
							tag:  q.addr[sscbf_pkg::TAG_LSB +: sscbf_pkg::TAG_W],
							data: d.lbuf};
						d.vict[q.cache] = q.way + 1'b1;
						d.st = sscbf_pkg::ST_IDLE;
					end
				end
			end
			sscbf_pkg::ST_WT: begin
				if (mem_ack) begin
					d.d_ack = 1'b1;
					d.st    = sscbf_pkg::ST_IDLE;
				end
			end
			default: begin
				d.st = sscbf_pkg::ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			q    <= '0;
			q.st <= sscbf_pkg::ST_IDLE;
		end else begin
			q <= d;
		end
	end

	// Outputs except mem_ready come from flip-flops; address and data lines are apart
	assign i_ack        = q.i_ack;
	assign i_rdata      = q.i_rdata;
	assign d_ack        = q.d_ack;
	assign d_rdata      = q.d_rdata;
	assign snp_hit      = q.snp_hit;
	assign snp_conflict = q.snp_conflict;
	assign bus_start    = q.bus_start;
	assign bus_addr     = q.bus_addr;
	assign bus_write    = q.bus_write;
	assign bus_burst    = q.bus_burst;
	assign bus_wdata    = q.bus_wdata;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	snoop_first_a: assert property (snp_act |=> !i_ack)
		else $error("client fetch granted during snoop");
	snoop_filter_a: assert property (!snp_act |=> !snp_hit && !snp_conflict)
		else $error("unsnoopable cycle produced a snoop answer");
	read_dcache_a: assert property (snp_act && !snp_write && !(|sdhit)
		|=> !snp_hit)
		else $error("snooped read answered by instruction cache");
	conflict_dirty_a: assert property (snp_act && (|sddirty)
		|=> snp_conflict && snp_hit)
		else $error("dirty snoop hit not flagged");
	write_inval_a: assert property (snp_act && snp_write ##1 snp_act
		&& snp_write && $stable(snp_addr) |-> !(|sdhit) && !(|sihit))
		else $error("snooped write left a valid line");
	wb_five_a: assert property (bus_start && bus_write && bus_burst
		##1 mem_ack [*4] |=> bus_start && !bus_write && bus_burst)
		else $error("burst write not done in five cycles");
	line_align_a: assert property (bus_start && bus_burst
		|-> bus_addr[sscbf_pkg::IDX_LSB-1:0] == sscbf_pkg::LINE_OFS0)
		else $error("burst not line aligned");
	wt_noalloc_a: assert property (q.st == sscbf_pkg::ST_IDLE && d_new
		&& d_we && d_page_mode == sscbf_pkg::PM_WT && !snp_act
		|=> q.st == sscbf_pkg::ST_WT && bus_start && !bus_burst)
		else $error("write-through write took a line fill");
	busy_hit_a: assert property (q.st != sscbf_pkg::ST_IDLE && i_new
		&& |ihit && !snp_act |=> i_ack)
		else $error("hit stalled behind bus activity");
endmodule // sscbf_top

// ==== sscbf_mem_model.sv ====
// Purpose: Memory slave model on the far side of the system bus.
// Assumes: One bus cycle at a time; beats begin after bus_start.
// Notes:   slow acks every other cycle; idle read data keeps changing.
`timescale 1ns/1ps
module sscbf_mem_model (
	input  wire logic        clock,	// System clock
	input  wire logic        reset_n,	// Async reset, active low
	input  wire logic        slow,	// Ack every other cycle
	input  wire logic        bus_start,	// Address phase
	input  wire logic [31:0] bus_addr,	// Cycle address
	input  wire logic        bus_write,	// Write cycle
	input  wire logic        bus_burst,	// Four-beat burst
	input  wire logic [31:0] bus_wdata,	// Write beat
	input  wire logic        mem_ready,	// Read beat may be given
	output logic             mem_ack,	// Beat handshake
	output logic [31:0]      mem_rdata	// Read beat
);
	logic [31:0] mem [logic [31:0]];	// Sparse storage
	logic [31:0] base;
	logic        wr, act, tgl;
	int          n, len;
	// Unwritten words hold an address pattern
	function automatic logic [31:0] rd(input logic [31:0] a);
		return mem.exists(a) ? mem[a] : (a ^ 32'hc3c33c3c);
	endfunction
	// A read beat is held until the FIFO can take it, never dropped
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			act = 1'b0;
			tgl = 1'b0;
			wr = 1'b0;
			n = 0;
			len = 0;
			base = 32'h0;
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0;
		end else begin
			if (act && mem_ack && (wr || mem_ready)) begin
				if (wr) mem[base + 32'(4 * n)] = bus_wdata;
				n = n + 1;
				act = (n < len);
			end
			if (bus_start) begin
				act = 1'b1;
				wr = bus_write;
				base = bus_addr;
				n = 0;
				len = bus_burst ? 4 : 1;
			end
			tgl = ~tgl;
			mem_ack <= act && !(slow && tgl);
			mem_rdata <= (act && !wr) ? rd(base + 32'(4 * n)) : ~mem_rdata;
		end
	end
endmodule // sscbf_mem_model

// ==== sscbf_top_tb.sv ====
// Purpose: Self-checking bench for the split snooping cache.
// Assumes: Memory model answers bursts; bench plays the other master.
// Notes:   Table rows first, then snoop priority, concurrency, snoop and eviction cases.
`timescale 1ns/1ps
module sscbf_top_tb;
	typedef struct packed {
		logic        isd;
		logic        we;
		logic [1:0]  md;
		logic [31:0] a;
		logic [31:0] wd;
		logic [31:0] ex;
	} sscbf_row_t;
	logic        clock, reset_n, slow, i_req, i_ack, d_req, d_we, d_ack;
	logic [31:0] i_addr, i_rdata, d_addr, d_wdata, d_rdata, snp_addr, q;
	logic [1:0]  d_page_mode;
	logic        snp_valid, snp_snoopable, snp_write, snp_hit, snp_conflict;
	logic        bus_start, bus_write, bus_burst, mem_ack, mem_ready, bwr;
	logic [31:0] bus_addr, bus_wdata, mem_rdata;
	int          err_count, cmp_count, bcyc, backs, nwb, n, dd;
	sscbf_row_t  rows [11];
	sscbf_top u_dut (.clock, .reset_n, .i_req, .i_addr, .i_ack, .i_rdata,
		.d_req, .d_we, .d_addr, .d_wdata, .d_page_mode, .d_ack, .d_rdata,
		.snp_valid, .snp_snoopable, .snp_write, .snp_addr, .snp_hit,
		.snp_conflict, .bus_start, .bus_addr, .bus_write, .bus_burst,
		.bus_wdata, .mem_ack, .mem_rdata, .mem_ready);
	sscbf_mem_model u_mem (.clock, .reset_n, .slow, .bus_start, .bus_addr,
		.bus_write, .bus_burst, .bus_wdata, .mem_ready, .mem_ack, .mem_rdata);
	initial clock = 1'b0;
	always #12.5 clock = ~clock;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask
	// Request held until its ack, dropped at the edge after
	task automatic acc(input sscbf_row_t r, output logic [31:0] rq,
		output int cyc);
		@(posedge clock);
		if (r.isd) begin
			d_req <= 1'b1;
			d_we <= r.we;
			d_page_mode <= r.md;
			d_addr <= r.a;
			d_wdata <= r.wd;
		end else begin
			i_req <= 1'b1;
			i_addr <= r.a;
		end
		cyc = 0;
		do begin
			@(posedge clock);
			#1;
			cyc++;
		end while ((r.isd ? d_ack : i_ack) !== 1'b1 && cyc < 500);
		rq = r.isd ? d_rdata : i_rdata;
		chk(cyc < 500, 1);
		@(posedge clock);
		if (r.isd) d_req <= 1'b0;
		else i_req <= 1'b0;
	endtask
	// One cycle of another master; answer looked at one cycle later
	task automatic snoop(input logic w, input logic s, input logic [31:0] a,
		input logic eh, input logic ec);
		@(posedge clock);
		snp_valid <= 1'b1;
		snp_snoopable <= s;
		snp_write <= w;
		snp_addr <= a;
		@(posedge clock);
		snp_valid <= 1'b0;
		#1;
		chk(snp_hit, eh);
		chk(snp_conflict, ec);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Burst watcher: aligned start, four beats, write done in five cycles
	always @(posedge clock) begin
		if (reset_n && bus_start && bus_burst) begin
			bcyc = 1;
			backs = 0;
			bwr = bus_write;
			nwb += int'(bus_write);
			chk(bus_addr[3:0], 4'h0);
		end else if (bcyc > 0) begin
			bcyc++;
			if (mem_ack && (bwr || mem_ready)) backs++;
			if (backs == 4) begin
				if (bwr && !slow) chk(bcyc <= 5, 1);
				bcyc = 0;
			end
		end
	end
	// Watchdog, far beyond the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		complete_run;
	end
	initial begin
		{i_req, d_req, d_we, snp_valid, snp_snoopable, snp_write} = 6'h00;
		{i_addr, d_addr, d_wdata, snp_addr} = 128'h0;
		{slow, d_page_mode, err_count, cmp_count, bcyc, nwb, dd} = '0;
		reset_n = 1'b0;
		rows = '{'{0, 0, 2'h1, 32'h100, 0, 32'hc3c33d3c},
			'{0, 0, 2'h1, 32'h104, 0, 32'hc3c33d38},
			'{1, 0, 2'h1, 32'h200, 0, 32'hc3c33e3c},
			'{1, 1, 2'h1, 32'h204, 32'h11110001, 0},
			'{1, 0, 2'h1, 32'h204, 0, 32'h11110001},
			'{1, 1, 2'h0, 32'h208, 32'h22220002, 0},
			'{1, 0, 2'h0, 32'h208, 0, 32'h22220002},
			'{1, 1, 2'h2, 32'h3000, 32'h33330003, 0},
			'{1, 0, 2'h3, 32'h3000, 0, 32'h33330003},
			'{1, 1, 2'h0, 32'h4000, 32'h44440004, 0},
			'{1, 0, 2'h1, 32'h4000, 0, 32'h44440004}};
		repeat (10) @(posedge clock);
		#1;
		chk({i_ack, d_ack, snp_hit, bus_start, mem_ready}, 5'h01);
		@(posedge clock);
		reset_n <= 1'b1;
		foreach (rows[k]) begin
			acc(rows[k], q, n);
			if (!rows[k].we) chk(q, rows[k].ex);
		end
		$display("rows done");
		// Client held off while snoop cycles run back to back
		@(posedge clock);
		i_req <= 1'b1;
		i_addr <= 32'h104;
		// Writes to a cached data line, so back-to-back invalidation is seen
		{snp_valid, snp_snoopable, snp_write, snp_addr} <= {3'h7, 32'h4000};
		repeat (3) begin
			@(posedge clock);
			#1;
			chk(i_ack, 0);
		end
		@(posedge clock);
		snp_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (i_ack !== 1'b1 && n < 4);
		chk(n, 1);
		chk(i_rdata, 32'hc3c33d38);
		@(posedge clock);
		i_req <= 1'b0;
		$display("snoop priority done");
		// Fetch hit while a slow data fill holds the bus
		@(posedge clock);
		slow <= 1'b1;
		fork
			begin
				acc('{1, 0, 2'h1, 32'h9000, 0, 0}, q, n);
				chk(q, 32'hc3c3ac3c);
				dd = 1;
			end
			begin
				repeat (3) @(posedge clock);
				acc('{0, 0, 2'h1, 32'h104, 0, 0}, q, n);
				chk(n, 1);
				chk(dd, 0);
				// Checked here: the slower data thread overwrites q later
				chk(q, 32'hc3c33d38);
			end
		join
		@(posedge clock);
		slow <= 1'b0;
		$display("concurrency done");
		// Snoop outcomes by cache, line state and cycle type
		acc('{1, 0, 2'h1, 32'h500, 0, 0}, q, n);
		snoop(0, 1, 32'h500, 1, 0);
		acc('{1, 1, 2'h1, 32'h504, 32'h55550005, 0}, q, n);
		snoop(0, 1, 32'h504, 1, 1);
		snoop(1, 0, 32'h500, 0, 0);
		snoop(1, 1, 32'h500, 1, 1);
		u_mem.mem[32'h500] = 32'h66660006;
		snoop(1, 1, 32'h500, 0, 0);
		acc('{1, 0, 2'h1, 32'h500, 0, 0}, q, n);
		chk(q, 32'h66660006);
		snoop(0, 1, 32'h100, 0, 0);
		snoop(1, 1, 32'h100, 1, 0);
		snoop(1, 1, 32'h100, 0, 0);
		acc('{1, 1, 2'h0, 32'h6000, 32'h77770007, 0}, q, n);
		snoop(0, 1, 32'h6000, 0, 0);
		// Snooped write lands while that line is being filled
		fork
			acc('{1, 0, 2'h1, 32'h700, 0, 0}, q, n);
			begin
				@(posedge clock);
				snoop(1, 1, 32'h700, 0, 0);
				u_mem.mem[32'h700] = 32'h88880008;
			end
		join
		chk(q, 32'h88880008);
		$display("snoop done");
		// Fill one set past its ways to push the dirty line out
		for (int k = 1; k <= 8; k++) begin
			acc('{1, 0, 2'h1, 32'h200 + 32'(k * 1024), 0, 0}, q, n);
		end
		chk(nwb > 0, 1);
		acc('{1, 0, 2'h1, 32'h204, 0, 0}, q, n);
		chk(q, 32'h11110001);
		acc('{1, 0, 2'h1, 32'h208, 0, 0}, q, n);
		chk(q, 32'h22220002);
		$display("eviction done");
		complete_run;
	end
endmodule // sscbf_top_tb
